//--- design/ssm_top.sv
// stop, scan and interactive mode control of a serial indexer
//
// Notes on behaviour
// - buffer flag 0: stop flushes command buffer
// - buffer flag 1: stop ends move only
// - interactive on at 0, address must be one
// - reply '>' if understood, '?' otherwise
// - replies preceded by line feed, return
// - banner then '>' at power-up and reboot
// - hold '>' while loop or sequence defined
// - interactive flag 1: no replies at all
// - scan enabled: run sequence from BCD inputs
// - interrupted run: selects go inactive first
// - stop ends scanning unless keep switch on
// - scan disabled: sequences only from serial
// - registration enable 1 allows, 0 disables
// - registration overrides trigger one uses
// - pause flag 0: stop aborts and flushes
// - pause flag 1: stop suspends, resume continues
// - paused move continues on resume
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "ssm_cfg.svh"

module ssm_top #(
    parameter int SEL_DIGITS = 2,
    parameter int BANNER_LEN = 6,
    parameter logic [8*BANNER_LEN-1:0] BANNER = 48'h2a5245414459
) (
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    rstn,
    // register port
    input  wire logic [3:0]              reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [31:0]                  reg_rdata,
    // buffered setting commands, from the command buffer in order
    input  wire logic                    set_valid,
    input  wire ssm_pkg::ssm_setcmd_t    set_cmd,
    // parsed command events
    input  wire logic                    cmd_done,
    input  wire logic                    cmd_ok,
    input  wire logic                    defining,
    input  wire logic                    halt_cmd,
    input  wire logic                    resume_order,
    input  wire logic                    reboot_op,
    input  wire logic [3:0]              device_addr,
    // pins
    input  wire logic                    stop_pin,
    input  wire logic                    trig_one_pin,
    input  wire logic [4*SEL_DIGITS-1:0] seq_sel_pin,
    // execution control
    input  wire logic                    seq_busy,
    output logic                         flush_buffer,
    output logic                         abort_move,
    output logic                         abort_seq,
    output logic                         paused,
    output logic                         pause_clear,
    output logic                         seq_start,
    output logic [4*SEL_DIGITS-1:0]      seq_number,
    output logic                         reg_armed,
    // serial transmit
    input  wire logic                    tx_ready,
    output logic                         tx_valid,
    output logic [7:0]                   tx_data
);
    localparam int SW = 4 * SEL_DIGITS;
    // *****************************
    // reset and pin synchronisers
    // *****************************
    logic [1:0]    rst_sync;
    logic          rst_n;
    logic [1:0]    stop_sync;
    logic [1:0]    trig_sync;
    logic [SW-1:0] sel_meta;
    logic [SW-1:0] sel_sync;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];
    // stop and trigger pins idle high: start there so that no false edge follows reset; selects start at zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stop_sync <= 2'h3;
            trig_sync <= 2'h3;
            sel_meta  <= '0;
            sel_sync  <= '0;
        end else begin
            stop_sync <= {stop_sync[0], stop_pin};
            trig_sync <= {trig_sync[0], trig_one_pin};
            sel_meta  <= seq_sel_pin;
            sel_sync  <= sel_meta;
        end
    end
    // *****************************
    // settings
    // *****************************
    ssm_pkg::ssm_settings_t cfg;
    ssm_pkg::ssm_settings_t next_cfg;
    logic [2:0]             tu_bits;
    // trigger-one uses are exclusive with each other and registration
    always_comb begin
        next_cfg = cfg;
        tu_bits  = 3'h0;
        if (set_valid) begin
            unique case (set_cmd.sel)
                `SSM_SEL_KEEP_BUF:
                    next_cfg.stop_keeps_buffer_setting = set_cmd.value;
                `SSM_SEL_INTERACT:
                    next_cfg.interactive_mode_setting = set_cmd.value;
                `SSM_SEL_SCAN:
                    next_cfg.continuous_scan_setting = set_cmd.value;
                `SSM_SEL_REG: begin
                    next_cfg.registration_enable = set_cmd.value;
                    if (set_cmd.value) begin
                        next_cfg.trig_pclr = 1'b0;
                        next_cfg.trig_halt = 1'b0;
                        next_cfg.trig_strb = 1'b0;
                    end
                end
                `SSM_SEL_PAUSE:
                    next_cfg.stop_as_pause_setting = set_cmd.value;
                `SSM_SEL_IRUN:
                    next_cfg.interrupted_run_mode = set_cmd.value;
                `SSM_SEL_KEEP_SCAN:
                    next_cfg.keep_scan_after_halt = set_cmd.value;
                `SSM_SEL_TRIG_USE:
                    tu_bits = reg_wdata[2:0];
            endcase
        end
        if (reg_wr && reg_addr == `SSM_REG_CTRL) begin
            tu_bits = reg_wdata[2:0];
        end
        if (tu_bits != 3'h0) begin
            next_cfg.trig_pclr = tu_bits[`SSM_TU_PCLR];
            next_cfg.trig_halt = tu_bits[`SSM_TU_HALT] & ~tu_bits[`SSM_TU_PCLR];
            next_cfg.trig_strb = tu_bits[`SSM_TU_STRB] & ~|tu_bits[1:0];
            next_cfg.registration_enable = 1'b0;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= ssm_pkg::ssm_settings_t'(`SSM_SET_RST);
        end else begin
            cfg <= next_cfg;
        end
    end
    // *****************************
    // stop and resume
    // *****************************
    logic trig_q;
    logic trig_fall;
    logic trig_on;
    logic stop_q;
    logic stop_ev;
    logic scanning;
    // pins are active when grounded
    assign trig_on   = ~trig_sync[1];
    assign trig_fall = trig_on & ~trig_q;
    // registration takes trigger one away from its other uses
    assign stop_ev = halt_cmd | (~stop_sync[1] & ~stop_q) |
        (trig_fall & cfg.trig_halt & ~cfg.registration_enable);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            trig_q       <= 1'b0;
            stop_q       <= 1'b0;
            flush_buffer <= 1'b0;
            abort_move   <= 1'b0;
            abort_seq    <= 1'b0;
            paused       <= 1'b0;
            pause_clear  <= 1'b0;
            reg_armed    <= 1'b0;
        end else begin
            trig_q       <= trig_on;
            stop_q       <= ~stop_sync[1];
            reg_armed    <= cfg.registration_enable;
            abort_move   <= stop_ev & ~cfg.stop_as_pause_setting;
            abort_seq    <= stop_ev & ~cfg.stop_as_pause_setting &
                            ~cfg.stop_keeps_buffer_setting;
            flush_buffer <= stop_ev & ~cfg.stop_as_pause_setting &
                            ~cfg.stop_keeps_buffer_setting;
            pause_clear  <= trig_fall & cfg.trig_pclr &
                            ~cfg.registration_enable;
            if (stop_ev && cfg.stop_as_pause_setting) begin
                paused <= 1'b1;
            end else if (resume_order || pause_clear) begin
                paused <= 1'b0;
            end
        end
    end
    // *****************************
    // continuous sequence scan
    // *****************************
    logic    bcd_ok;
    logic    sel_idle;
    logic    strobe_ok;
    logic    armed;
    function automatic logic bcd_valid(input logic [SW-1:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < SEL_DIGITS; i++) begin
            if (v[4*i +: 4] > `SSM_BCD_MAX) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction
    assign bcd_ok    = bcd_valid(sel_sync) & (sel_sync != '0);
    assign sel_idle  = (sel_sync == '0);
    assign strobe_ok = ~cfg.trig_strb | cfg.registration_enable |
                       trig_fall;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scanning   <= 1'b1;
            armed      <= 1'b1;
            seq_start  <= 1'b0;
            seq_number <= '0;
        end else begin
            seq_start <= 1'b0;
            if (stop_ev && !cfg.keep_scan_after_halt) begin
                scanning <= 1'b0;
            end else if (!cfg.continuous_scan_setting) begin
                scanning <= 1'b1;
            end
            if (sel_idle) begin
                armed <= 1'b1;
            end
            if (cfg.continuous_scan_setting && scanning && !paused &&
                !seq_busy && !seq_start && bcd_ok && strobe_ok &&
                (armed || !cfg.interrupted_run_mode)) begin
                seq_start  <= 1'b1;
                seq_number <= sel_sync;
                armed      <= 1'b0;
            end
        end
    end
    // *****************************
    // interactive replies
    // *****************************
    ssm_pkg::ssm_tx_state_t tx_state;
    logic [7:0]             reply;
    logic [7:0]             ban_idx;
    logic                   boot_req;
    logic                   interactive;
    assign interactive = ~cfg.interactive_mode_setting &
                         (device_addr == `SSM_ADDR_ONE);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_state <= ssm_pkg::TX_IDLE;
            reply    <= `SSM_CH_OK;
            ban_idx  <= 8'h0;
            boot_req <= 1'b1;
            tx_valid <= 1'b0;
            tx_data  <= 8'h0;
        end else begin
            unique case (tx_state)
                ssm_pkg::TX_IDLE: begin
                    if (boot_req) begin
                        boot_req <= 1'b0;
                        if (interactive) begin
                            ban_idx  <= 8'h0;
                            reply    <= `SSM_CH_OK;
                            tx_state <= ssm_pkg::TX_BANNER;
                        end
                    end else if (cmd_done && interactive &&
                                 !(cmd_ok && defining)) begin
                        reply    <= cmd_ok ? `SSM_CH_OK
                                           : `SSM_CH_BAD;
                        tx_state <= ssm_pkg::TX_LF;
                    end
                end
                ssm_pkg::TX_BANNER: begin
                    if (!tx_valid || tx_ready) begin
                        tx_valid <= 1'b1;
                        tx_data  <= BANNER[8*(BANNER_LEN-1-int'(ban_idx))
                                           +: 8];
                        ban_idx  <= ban_idx + 8'h1;
                        if (int'(ban_idx) == BANNER_LEN - 1) begin
                            tx_state <= ssm_pkg::TX_LF;
                        end
                    end
                end
                ssm_pkg::TX_LF: begin
                    if (!tx_valid || tx_ready) begin
                        tx_valid <= 1'b1;
                        tx_data  <= `SSM_CH_LF;
                        tx_state <= ssm_pkg::TX_CR;
                    end
                end
                ssm_pkg::TX_CR: begin
                    if (tx_ready) begin
                        tx_data  <= `SSM_CH_CR;
                        tx_state <= ssm_pkg::TX_CHAR;
                    end
                end
                ssm_pkg::TX_CHAR: begin
                    if (tx_ready) begin
                        tx_data  <= reply;
                        tx_state <= ssm_pkg::TX_IDLE;
                    end
                end
            endcase
            if (tx_state == ssm_pkg::TX_IDLE && tx_valid && tx_ready) begin
                tx_valid <= 1'b0;
            end
            if (reboot_op) begin
                boot_req <= 1'b1;
            end
        end
    end
    // *****************************
    // register port
    // *****************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `SSM_REG_CTRL: reg_rdata <= {22'h0, cfg};
                `SSM_REG_STAT: reg_rdata <= {26'h0, scanning, armed,
                                             paused, interactive,
                                             trig_on, ~stop_sync[1]};
                `SSM_REG_SEQ:  reg_rdata <= 32'(seq_number);
                default:       reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end
endmodule

//--- design/ssm_cfg.svh
// constants for the stop, scan and mode control block
`ifndef SSM_CFG_SVH
`define SSM_CFG_SVH

// setting selector codes
`define SSM_SEL_KEEP_BUF   3'h0
`define SSM_SEL_INTERACT   3'h1
`define SSM_SEL_SCAN       3'h2
`define SSM_SEL_REG        3'h3
`define SSM_SEL_PAUSE      3'h4
`define SSM_SEL_IRUN       3'h5
`define SSM_SEL_KEEP_SCAN  3'h6
`define SSM_SEL_TRIG_USE   3'h7

// trigger-one use bit positions
`define SSM_TU_PCLR        0
`define SSM_TU_HALT        1
`define SSM_TU_STRB        2

// settings reset value and interactive address
`define SSM_SET_RST        10'h000
`define SSM_ADDR_ONE       4'h1

// reply characters
`define SSM_CH_LF          8'h0a
`define SSM_CH_CR          8'h0d
`define SSM_CH_OK          8'h3e
`define SSM_CH_BAD         8'h3f

// bcd digit limit
`define SSM_BCD_MAX        4'h9

// register offsets
`define SSM_REG_CTRL       4'h0
`define SSM_REG_STAT       4'h4
`define SSM_REG_SEQ        4'h8

`endif

//--- design/ssm_pkg.sv
// types for the stop, scan and mode control block
package ssm_pkg;

    typedef struct packed {
        logic       trig_strb;
        logic       trig_halt;
        logic       trig_pclr;
        logic       keep_scan_after_halt;
        logic       interrupted_run_mode;
        logic       stop_as_pause_setting;
        logic       registration_enable;
        logic       continuous_scan_setting;
        logic       interactive_mode_setting;
        logic       stop_keeps_buffer_setting;
    } ssm_settings_t;

    typedef struct packed {
        logic [2:0] sel;
        logic       value;
    } ssm_setcmd_t;

    typedef enum logic [4:0] {
        TX_IDLE   = 5'b00001,
        TX_BANNER = 5'b00010,
        TX_LF     = 5'b00100,
        TX_CR     = 5'b01000,
        TX_CHAR   = 5'b10000
    } ssm_tx_state_t;

endpackage

//--- sim/ssm_host.sv
// host model: serial sink for the indexer's replies
`timescale 1ns/1ps
module ssm_host (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // stall control
    input  wire logic       slow,
    // reply stream
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    logic [7:0] rx [0:63];
    int         rx_cnt;
    logic       ph;
    // a slow host takes a byte every other cycle only
    assign tx_ready = !slow || ph;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ph <= 1'b0;
            rx_cnt <= 0;
        end else begin
            ph <= !ph;
            if (tx_valid && tx_ready) begin
                rx[rx_cnt[5:0]] <= tx_data;
                rx_cnt <= rx_cnt + 1;
            end
        end
    end
endmodule

//--- sim/ssm_top_chk.sv
// assertions on the ports of the stop, scan and mode block
`timescale 1ns/1ps
`include "ssm_cfg.svh"
module ssm_top_chk #(
    parameter int SEL_DIGITS = 2
) (
    // clock and reset
    input wire logic                    clock,
    input wire logic                    rstn,
    // commands
    input wire logic                    set_valid,
    input wire ssm_pkg::ssm_setcmd_t    set_cmd,
    input wire logic                    halt_cmd,
    input wire logic                    resume_order,
    input wire logic [3:0]              device_addr,
    // execution
    input wire logic                    flush_buffer,
    input wire logic                    abort_move,
    input wire logic                    abort_seq,
    input wire logic                    paused,
    input wire logic                    pause_clear,
    input wire logic                    seq_start,
    input wire logic [4*SEL_DIGITS-1:0] seq_number,
    input wire logic                    reg_armed,
    // serial
    input wire logic                    tx_ready,
    input wire logic                    tx_valid,
    input wire logic [7:0]              tx_data
);
    // ****************
    // settings shadow
    // ****************
    logic keepb, pau, quiet, scan;
    wire  acc = tx_valid && tx_ready;
    wire  mute = quiet || device_addr != `SSM_ADDR_ONE;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {keepb, pau, quiet, scan} <= 4'h0;
        end else if (set_valid) begin
            case (set_cmd.sel)
                `SSM_SEL_KEEP_BUF: keepb <= set_cmd.value;
                `SSM_SEL_PAUSE:    pau <= set_cmd.value;
                `SSM_SEL_INTERACT: quiet <= set_cmd.value;
                `SSM_SEL_SCAN:     scan <= set_cmd.value;
                default:           ;
            endcase
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_halt_flush: assert property (halt_cmd && !keepb && !pau && !paused
        |=> abort_move && abort_seq && flush_buffer) else $error("no flush");
    a_halt_keep: assert property (halt_cmd && keepb && !pau && !paused
        |=> abort_move && !abort_seq && !flush_buffer) else $error("kept bad");
    a_halt_pause: assert property (halt_cmd && pau
        |=> paused && !abort_move && !flush_buffer) else $error("no pause");
    a_resume_go: assert property (paused && resume_order
        |-> ##[1:2] !paused) else $error("no resume");
    a_lf_then_cr: assert property (acc && tx_data == `SSM_CH_LF
        |=> tx_valid && tx_data == `SSM_CH_CR) else $error("no cr");
    a_cr_then_ans: assert property (acc && tx_data == `SSM_CH_CR
        |=> tx_valid && tx_data inside {`SSM_CH_OK, `SSM_CH_BAD})
        else $error("bad answer");
    a_tx_hold: assert property (tx_valid && !tx_ready
        |=> tx_valid && $stable(tx_data)) else $error("byte dropped");
    a_quiet_mode: assert property (!tx_valid && mute && $past(mute)
        |=> !tx_valid) else $error("reply when quiet");
    a_scan_off: assert property (seq_start
        |-> scan || $past(scan) || $past(scan, 2)) else $error("scan off");
    a_bcd_num: assert property (seq_start |-> seq_number[3:0] <= 4'h9
        && seq_number[7:4] <= 4'h9 && seq_number != 0) else $error("bad bcd");
    a_reg_override: assert property (reg_armed |-> !pause_clear)
        else $error("trigger not overridden");
    c_pause: cover property (halt_cmd && pau);
    c_start: cover property (seq_start);
    c_bad: cover property (acc && tx_data == `SSM_CH_BAD);
    c_armed: cover property (reg_armed);
endmodule

bind ssm_top ssm_top_chk #(.SEL_DIGITS(SEL_DIGITS)) i_chk (
    .clock(clock), .rstn(rstn), .set_valid(set_valid), .set_cmd(set_cmd),
    .halt_cmd(halt_cmd), .resume_order(resume_order),
    .device_addr(device_addr), .flush_buffer(flush_buffer),
    .abort_move(abort_move), .abort_seq(abort_seq), .paused(paused),
    .pause_clear(pause_clear), .seq_start(seq_start),
    .seq_number(seq_number), .reg_armed(reg_armed), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data));

//--- sim/test_ssm_top.sv
// self-checking bench for the stop, scan and mode block
`timescale 1ns/1ps
`include "ssm_cfg.svh"
module test_ssm_top;
    logic clock = 0, rstn = 0, reg_wr = 0, reg_rd = 0, set_valid = 0;
    logic cmd_done = 0, cmd_ok = 0, defining = 0, halt_cmd = 0;
    logic resume_order = 0, reboot_op = 0, stop_pin = 1, trig_one_pin = 1;
    logic seq_busy = 0, slow = 0, tx_ready, tx_valid, flush_buffer;
    logic abort_move, abort_seq, paused, pause_clear, seq_start, reg_armed;
    logic [3:0]  reg_addr = 0, device_addr = 4'h1;
    logic [31:0] reg_wdata = 0, reg_rdata, d;
    logic [7:0]  seq_sel_pin = 0, seq_number, tx_data;
    ssm_pkg::ssm_setcmd_t set_cmd = '0;
    int failures = 0, checked = 0, cyc = 0, c;
    localparam logic [47:0] BAN = 48'h2a5245414459;
    always #2.5 clock = ~clock;
    ssm_top i_dut (.clock(clock), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .set_valid(set_valid), .set_cmd(set_cmd),
        .cmd_done(cmd_done), .cmd_ok(cmd_ok), .defining(defining),
        .halt_cmd(halt_cmd), .resume_order(resume_order),
        .reboot_op(reboot_op), .device_addr(device_addr),
        .stop_pin(stop_pin), .trig_one_pin(trig_one_pin),
        .seq_sel_pin(seq_sel_pin), .seq_busy(seq_busy),
        .flush_buffer(flush_buffer), .abort_move(abort_move),
        .abort_seq(abort_seq), .paused(paused), .pause_clear(pause_clear),
        .seq_start(seq_start), .seq_number(seq_number),
        .reg_armed(reg_armed), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data));
    ssm_host i_host (.clock(clock), .rstn(rstn), .slow(slow),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 0;
        #1 d = reg_rdata;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 0;
    endtask
    task automatic setc(input logic [2:0] s, input logic v);
        @(posedge clock);
        set_valid <= 1;
        set_cmd <= {s, v};
        @(posedge clock);
        set_valid <= 0;
        tick(2);
    endtask
    task automatic halt;
        @(posedge clock);
        halt_cmd <= 1;
        @(posedge clock);
        halt_cmd <= 0;
        #1;
    endtask
    task automatic starts(input int n);
        c = 0;
        repeat (n) begin
            tick(1);
            if (seq_start === 1'b1) c++;
        end
    endtask
    task automatic banner(input int b);
        tick(40);
        chk(i_host.rx_cnt, b + 9);
        for (int i = 0; i < 6; i++) chk(i_host.rx[b+i], BAN[8*(5-i)+:8]);
        chk({i_host.rx[b+6], i_host.rx[b+7]}, 16'h0a0d);
        chk(i_host.rx[b+8], `SSM_CH_OK);
    endtask
    // ch zero means that no reply is expected
    task automatic reply(input logic ok, input logic df, input logic [7:0] ch);
        int b;
        b = i_host.rx_cnt;
        @(posedge clock);
        cmd_done <= 1;
        cmd_ok <= ok;
        defining <= df;
        @(posedge clock);
        cmd_done <= 0;
        tick(30);
        defining <= 0;
        chk(i_host.rx_cnt, b + (ch != 0 ? 3 : 0));
        if (ch != 0) begin
            chk({i_host.rx[b], i_host.rx[b+1]}, 16'h0a0d);
            chk(i_host.rx[b+2], ch);
        end
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_prompt;
        banner(0);
        @(posedge clock);
        reboot_op <= 1;
        @(posedge clock);
        reboot_op <= 0;
        banner(9);
        slow <= 1;
        reply(1, 0, `SSM_CH_OK);
        reply(0, 0, `SSM_CH_BAD);
        reply(1, 1, 8'h00);
        device_addr <= 4'h2;
        reply(1, 0, 8'h00);
        device_addr <= `SSM_ADDR_ONE;
        setc(`SSM_SEL_INTERACT, 1);
        reply(0, 0, 8'h00);
        setc(`SSM_SEL_INTERACT, 0);
    endtask
    task automatic t_stop;
        halt;
        chk({abort_move, abort_seq, flush_buffer}, 3'h7);
        setc(`SSM_SEL_KEEP_BUF, 1);
        halt;
        chk({abort_move, abort_seq, flush_buffer}, 3'h4);
        setc(`SSM_SEL_KEEP_BUF, 0);
        stop_pin <= 0;
        for (int i = 0; i < 8 && abort_move !== 1'b1; i++) tick(1);
        chk(flush_buffer, 1);
        stop_pin <= 1;
    endtask
    task automatic t_pause;
        rd(`SSM_REG_CTRL);
        chk(d, 0);
        rd(4'hc);
        chk(d, 0);
        wr(`SSM_REG_CTRL, 32'h2);
        trig_one_pin <= 0;
        for (int i = 0; i < 8 && abort_move !== 1'b1; i++) tick(1);
        chk({abort_move, flush_buffer}, 2'h3);
        trig_one_pin <= 1;
        wr(`SSM_REG_CTRL, 32'h1);
        setc(`SSM_SEL_PAUSE, 1);
        halt;
        chk({paused, abort_move, flush_buffer}, 3'h4);
        trig_one_pin <= 0;
        tick(6);
        chk(paused, 0);
        trig_one_pin <= 1;
        setc(`SSM_SEL_REG, 1);
        rd(`SSM_REG_CTRL);
        chk(d, 32'h18);
        chk(reg_armed, 1);
        halt;
        trig_one_pin <= 0;
        tick(6);
        chk(paused, 1);
        trig_one_pin <= 1;
        @(posedge clock);
        resume_order <= 1;
        @(posedge clock);
        resume_order <= 0;
        tick(2);
        chk(paused, 0);
        setc(`SSM_SEL_REG, 0);
        chk(reg_armed, 0);
        setc(`SSM_SEL_PAUSE, 0);
    endtask
    task automatic t_scan;
        seq_sel_pin <= 8'h12;
        starts(20);
        chk(c, 0);
        setc(`SSM_SEL_SCAN, 1);
        for (int i = 0; i < 20 && seq_start !== 1'b1; i++) tick(1);
        chk(seq_number, 8'h12);
        seq_sel_pin <= 0;
        setc(`SSM_SEL_IRUN, 1);
        seq_sel_pin <= 8'h12;
        starts(40);
        chk(c, 1);
        seq_sel_pin <= 0;
        tick(4);
        seq_sel_pin <= 8'h34;
        starts(40);
        chk(c, 1);
        setc(`SSM_SEL_IRUN, 0);
        halt;
        tick(4);
        starts(20);
        chk(c, 0);
        setc(`SSM_SEL_KEEP_SCAN, 1);
        setc(`SSM_SEL_SCAN, 0);
        setc(`SSM_SEL_SCAN, 1);
        halt;
        tick(4);
        seq_busy <= 1;
        starts(10);
        chk(c, 0);
        seq_busy <= 0;
        starts(20);
        chk(c != 0, 1);
        rd(`SSM_REG_SEQ);
        chk(d, 32'h34);
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            end_sim;
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1;
        repeat (3) @(posedge clock);
        t_prompt;
        t_stop;
        t_pause;
        t_scan;
        end_sim;
    end
endmodule
